//--- verification/berr_far_end.sv
// Far-end model of one serial port: slot timing plus loopback of a pattern.
// Assumes the tester answers a slot one cycle later; sixteen channels on stream 2.
`timescale 1ns/100ps
`default_nettype none
module berr_far_end (
   input wire logic pclk, // Clock
   input wire logic presetn, // Reset, active low
   input wire logic flip, // Invert the looped bit
   input wire berr_pkg::berr_tx_type loop_in, // Pattern looped back
   output berr_pkg::berr_slot_type tx_slot, // Output bit timing
   output berr_pkg::berr_slot_type rx_slot // Received bit
);
   import berr_pkg::*;
   // =====================================================
   // One bit slot per cycle; idle receive bits toggle so stale data never passes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_slot <= '0;
         rx_slot <= '0;
      end else begin
         tx_slot <= '{1'b1, 5'h02, {5'h00, tx_slot.channel[3:0] + 4'h1}, ~tx_slot.data};
         rx_slot <= '{loop_in.insert, 5'h02, tx_slot.channel, loop_in.insert ? loop_in.data ^ flip : ~rx_slot.data};
      end
   end
endmodule
`default_nettype wire

//--- verification/berr_tester_chk.sv
// Port checker for the PRBS error-rate tester.
// Assumes it is bound to berr_tester and sees only its ports, one clock domain.
`include "berr_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module berr_tester_chk #(
   parameter int COUNT_W = 16 // Error counter width
) (
   input wire logic pclk, // Clock
   input wire logic presetn, // Reset, active low
   input wire logic psel, // APB select
   input wire logic penable, // APB access phase
   input wire logic pwrite, // APB direction
   input wire logic [`BERR_ADDR_W-1:0] paddr, // APB address
   input wire logic [31:0] prdata, // APB read data
   input wire logic pready, // APB ready
   input wire logic pslverr, // APB error
   input wire logic irq, // Interrupt
   input wire berr_pkg::berr_slot_type local_tx_slot, // Local timing
   input wire berr_pkg::berr_slot_type bp_tx_slot, // Backplane timing
   input wire berr_pkg::berr_tx_type local_tx_out, // Local override
   input wire berr_pkg::berr_tx_type bp_tx_out // Backplane override
);
   import berr_pkg::*;
   // =====================================================
   // Recent writes: config levels may only move and irq may only fall shortly after one
   logic [2:0] wr_hist;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         wr_hist <= 3'h0;
      else
         wr_hist <= {wr_hist[1:0], psel & penable & pready & pwrite};
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_answer;
      psel && penable && pready ##1 !pready;
   endsequence
   // =====================================================
   // Bus and override relations
   chk_ready_walk: assert property (s_setup |=> s_answer)
      else $error("pready not a single pulse after setup");
   chk_ready_access: assert property (pready |-> psel && penable)
      else $error("pready outside access phase");
   chk_slverr_map: assert property (pready |-> pslverr == (paddr > `BERR_OFF_LOCK || paddr[1:0] != 2'h0))
      else $error("pslverr does not match address map");
   chk_prdata_hold: assert property ($changed(prdata) |-> $past(psel && !penable && !pwrite))
      else $error("prdata moved without a read setup");
   chk_insert_local: assert property (local_tx_out.insert |-> $past(local_tx_slot.valid) && local_tx_out.ignore_cm
      && local_tx_out.switch_blocked)
      else $error("local insert without slot or override");
   chk_insert_bp: assert property (bp_tx_out.insert |-> $past(bp_tx_slot.valid) && bp_tx_out.ignore_cm
      && bp_tx_out.switch_blocked)
      else $error("backplane insert without slot or override");
   chk_blocked_write: assert property ($changed(local_tx_out.switch_blocked) || $changed(bp_tx_out.switch_blocked)
      |-> |wr_hist)
      else $error("switch block moved without a write");
   chk_irq_clear: assert property ($fell(irq) |-> |wr_hist)
      else $error("irq fell without a write");
endmodule
bind berr_tester berr_tester_chk #(.COUNT_W(COUNT_W)) u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .irq(irq), .local_tx_slot(local_tx_slot), .bp_tx_slot(bp_tx_slot), .local_tx_out(local_tx_out),
   .bp_tx_out(bp_tx_out));
`default_nettype wire

//--- verification/testbench.sv
// Self-checking bench: APB sequences against the tester, two far-end models.
// Assumes no fixed APB latency; each far end loops its own port's pattern back.
`include "berr_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import berr_pkg::*;
   localparam logic [39:0] CFG[8] = '{40'h04_0000_0405, 40'h08_0000_0003, 40'h0C_0000_0400, 40'h10_0000_000F,
      40'h18_0000_0400, 40'h1C_0000_000F, 40'h20_0000_0400, 40'h24_0000_000F};
   logic pclk = 1'b0;
   logic presetn;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, flip_l = 1'b0, flip_b = 1'b0, se, el, eb;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
   logic pready, pslverr, irq;
   logic [22:0] hl = '0, hb = '0;
   berr_slot_type lts, lrs, bts, brs;
   berr_tx_type lto, bto;
   int err_total = 0, total_checks = 0, nl = 0, nb = 0, k;
   event hang;
   always #5 pclk = ~pclk;
   berr_tester uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
      .local_tx_slot(lts), .local_rx_slot(lrs), .bp_tx_slot(bts), .bp_rx_slot(brs),
      .local_tx_out(lto), .bp_tx_out(bto));
   // Each port loops back on itself; the two ports run different sequence lengths at once
   berr_far_end u_lfe (.pclk(pclk), .presetn(presetn), .flip(flip_l), .loop_in(lto), .tx_slot(lts), .rx_slot(lrs));
   berr_far_end u_bfe (.pclk(pclk), .presetn(presetn), .flip(flip_b), .loop_in(bto), .tx_slot(bts), .rx_slot(brs));
   // =====================================================
   // Reporting
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      total_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic conclude();
      if (err_total == 0 && total_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   initial begin
      @(hang);
      conclude();
   end
   // =====================================================
   // One APB transfer, request held until pready is sampled high
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      int t;
      t = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         t++;
      end while (pready !== 1'b1 && t < 20);
      if (pready !== 1'b1) begin
         err_total++;
         -> hang;
      end
      rd = prdata;
      se = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic irq_is(input logic e);
      repeat (2) @(negedge pclk);
      check(irq, e, "irq");
   endtask
   // =====================================================
   // Expected patterns: seed ones first, then the feedback taps
   always @(posedge pclk) begin
      el = nl < 15 ? 1'b1 : hl[14] ^ hl[13];
      eb = nb < 23 ? 1'b1 : hb[22] ^ hb[17];
      if (lto.insert === 1'b1) begin
         check(lto.data, el, "local pattern");
         hl = {hl[21:0], el};
         nl++;
      end
      if (bto.insert === 1'b1) begin
         check(bto.data, eb, "backplane pattern");
         hb = {hb[21:0], eb};
         nb++;
      end
   end
   // =====================================================
   // Main sequence
   initial begin
      presetn = 1'b0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      for (k = 0; k <= 32'h0000_0034; k += 4) begin
         xfer(1'b0, k[7:0], 32'h0);
         check(rd, 32'h0, "reset value");
      end
      xfer(1'b0, 8'h38, 32'h0);
      check(se, 32'h1, "unmapped error");
      check(rd, 32'h0, "unmapped data");
      // Receive start is the raw channel since no input delay is set here
      // Far ends take every inserted bit, as if window output enables were set
      foreach (CFG[i]) xfer(1'b1, CFG[i][39:32], CFG[i][31:0]);
      foreach (CFG[i]) begin
         xfer(1'b0, CFG[i][39:32], 32'h0);
         check(rd, CFG[i][31:0], "config readback");
      end
      xfer(1'b1, `BERR_OFF_INT_MASK, 32'h0000_0009);
      xfer(1'b1, `BERR_OFF_CTRL, 32'h0000_002F);
      @(negedge pclk);
      k = nl;
      repeat (32) @(negedge pclk);
      check(nl - k, 32'h8, "window bits");
      // Widen the local window to every channel so each flipped bit lands on a pattern bit
      xfer(1'b1, `BERR_OFF_L_TX_START, 32'h0000_0400);
      xfer(1'b1, `BERR_OFF_L_TX_LEN, 32'h0000_000F);
      k = 0;
      do begin
         xfer(1'b0, `BERR_OFF_LOCK, 32'h0);
         k++;
      end while (rd !== 32'h3 && k < 50);
      check(rd, 32'h3, "lock");
      if (rd !== 32'h3) -> hang;
      xfer(1'b0, `BERR_OFF_L_COUNT, 32'h0);
      check(rd, 32'h0, "count at lock");
      xfer(1'b0, `BERR_OFF_INT_STATUS, 32'h0);
      check(rd, 32'h9, "lock events");
      irq_is(1'b1);
      xfer(1'b1, `BERR_OFF_INT_STATUS, 32'h0000_003F);
      xfer(1'b0, `BERR_OFF_INT_STATUS, 32'h0);
      check(rd, 32'h0, "status cleared");
      irq_is(1'b0);
      xfer(1'b1, `BERR_OFF_INT_MASK, 32'h0);
      // Three single-bit errors locally, one on the backplane receiver
      repeat (3) begin
         @(posedge pclk);
         flip_l <= 1'b1;
         @(posedge pclk);
         flip_l <= 1'b0;
      end
      flip_b <= 1'b1;
      @(posedge pclk);
      flip_b <= 1'b0;
      repeat (4) @(posedge pclk);
      xfer(1'b0, `BERR_OFF_L_COUNT, 32'h0);
      check(rd, 32'h3, "local count");
      xfer(1'b0, `BERR_OFF_B_COUNT, 32'h0);
      check(rd, 32'h1, "backplane count");
      xfer(1'b0, `BERR_OFF_INT_STATUS, 32'h0);
      check(rd, 32'h12, "error events");
      irq_is(1'b0);
      xfer(1'b1, `BERR_OFF_INT_MASK, 32'h0000_0002);
      irq_is(1'b1);
      // Long error burst must stop at all ones
      flip_l <= 1'b1;
      repeat (65540) @(posedge pclk);
      flip_l <= 1'b0;
      xfer(1'b0, `BERR_OFF_L_COUNT, 32'h0);
      check(rd, 32'h0000_FFFF, "saturated count");
      xfer(1'b0, `BERR_OFF_INT_STATUS, 32'h0);
      check(rd[2], 32'h1, "saturation event");
      xfer(1'b1, `BERR_OFF_CTRL, 32'h0000_002B);
      xfer(1'b1, `BERR_OFF_CTRL, 32'h0000_002F);
      xfer(1'b0, `BERR_OFF_L_COUNT, 32'h0);
      check(rd, 32'h0, "count after restart");
      xfer(1'b0, `BERR_OFF_LOCK, 32'h0);
      check(rd, 32'h2, "lock after restart");
      @(negedge pclk);
      check(lto.switch_blocked, 32'h1, "switch blocked");
      check(lto.ignore_cm, 32'h1, "ignore connection");
      xfer(1'b1, `BERR_OFF_CTRL, 32'h0);
      repeat (2) @(negedge pclk);
      check(lto.switch_blocked, 32'h0, "switch released");
      conclude();
   end
endmodule
`default_nettype wire

//--- verilog/berr_consts.svh
// Register offsets, field positions, reset values and limits of the PRBS error-rate tester.
// Assumes byte addressing on a 32-bit APB bus, one aligned word per register.
`ifndef BERR_CONSTS_SVH
`define BERR_CONSTS_SVH

// =====================================================================
// Register byte offsets
`define BERR_ADDR_W 8
`define BERR_OFF_CTRL 8'h00
`define BERR_OFF_L_TX_START 8'h04
`define BERR_OFF_L_TX_LEN 8'h08
`define BERR_OFF_L_RX_START 8'h0C
`define BERR_OFF_L_RX_LEN 8'h10
`define BERR_OFF_L_COUNT 8'h14
`define BERR_OFF_B_TX_START 8'h18
`define BERR_OFF_B_TX_LEN 8'h1C
`define BERR_OFF_B_RX_START 8'h20
`define BERR_OFF_B_RX_LEN 8'h24
`define BERR_OFF_B_COUNT 8'h28
`define BERR_OFF_INT_STATUS 8'h2C
`define BERR_OFF_INT_MASK 8'h30
`define BERR_OFF_LOCK 8'h34

// =====================================================================
// Control register fields (port 0 local, port 1 backplane)
`define BERR_CTRL_W 6
`define BERR_CTRL_TX_LSB 0
`define BERR_CTRL_RX_LSB 2
`define BERR_CTRL_LONG_LSB 4

// Start register: channel in the low field, stream above it
`define BERR_CHAN_LSB 0
`define BERR_STREAM_LSB 9

// Interrupt status layout: three events per port
`define BERR_EV_PER_PORT 3
`define BERR_EV_LOCK 0
`define BERR_EV_ERR 1
`define BERR_EV_SAT 2

// =====================================================================
// Reset values
`define BERR_CTRL_RST 6'h00
`define BERR_START_RST 14'h0000
`define BERR_LEN_RST 9'h000
`define BERR_MASK_RST 6'h00
`define BERR_STATUS_RST 6'h00

// Sequence lengths
`define BERR_SHORT_LEN 15
`define BERR_LONG_LEN 23

`endif

//--- verilog/berr_pkg.sv
// Types shared by the PRBS error-rate tester and its surroundings.
// Assumes the switch core supplies per-bit slot timing on the tester clock.
package berr_pkg;

   localparam int BERR_STREAM_W = 5;
   localparam int BERR_CHAN_W = 9;
   localparam int BERR_LFSR_W = 23;

   // One bit time of a serial stream, as seen by the switch core
   typedef struct packed {
      logic valid;
      logic [BERR_STREAM_W-1:0] stream;
      logic [BERR_CHAN_W-1:0] channel;
      logic data;
   } berr_slot_type;

   // What the tester asks of the output path of one port
   typedef struct packed {
      logic insert;
      logic data;
      logic ignore_cm;
      logic switch_blocked;
   } berr_tx_type;

endpackage

//--- verilog/berr_tester.sv
// PRBS bit error rate tester for the local and backplane ports of a time-slot switch.
// Assumes the switch core presents slot timing and received bits on pclk, one bit per valid cycle.
// Functional notes
// [R1] Two independent testers, local and backplane, each with transmitter and receiver.
// [R2] Transmit and receive enables are independent, allowing any port-to-port combination.
// [R3] Transmitter generates a maximal-length sequence of period 2^15-1 or 2^23-1.
// [R4] Pattern goes on one output stream from start channel through length channels.
// [R5] Receiver checks one input stream over start channel plus length channels.
// [R6] Receiver searches for the seed, declares lock, counts nothing before lock.
// [R7] After lock every bit is compared; each mismatch increments a 16-bit counter.
// [R8] The error counter saturates at all ones and never wraps.
// [R9] Control register holds separate transmit and receive enables for both ports.
// [R10] Per port, transmit start holds stream and channel; transmit length the count.
// [R11] Per port, receive start holds stream and channel; receive length the count.
// [R12] Per port, a count register shows the error counter to software.
// [R13] Transmit window channels ignore connection memory source and message bits.
// [R14] Software sets channel output enables high for the transmit window channels.
// [R15] Receive channels ignore input delay; software adds the delay to the start.
// [R16] While transmitting, other channels of that port carry undefined data.
// [R17] Polynomials x^15+x^14+1 and x^23+x^18+1, identical in transmitter and receiver.
// [R18] Counter and lock clear on receive enable rising, and on reset.
`include "berr_consts.svh"
`timescale 1ns/100ps
`default_nettype none

module berr_tester #(
   parameter int COUNT_W = 16 // Error counter width
) (
   input wire logic pclk, // Bus and core clock, 100 MHz
   input wire logic presetn, // Asynchronous reset, active low
   input wire logic psel, // APB select
   input wire logic penable, // APB access phase
   input wire logic pwrite, // APB direction, high for write
   input wire logic [`BERR_ADDR_W-1:0] paddr, // APB byte address
   input wire logic [31:0] pwdata, // APB write data
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error, unmapped address
   output logic irq, // Level interrupt
   input wire berr_pkg::berr_slot_type local_tx_slot, // Local output bit timing
   input wire berr_pkg::berr_slot_type local_rx_slot, // Local input bit and timing
   input wire berr_pkg::berr_slot_type bp_tx_slot, // Backplane output bit timing
   input wire berr_pkg::berr_slot_type bp_rx_slot, // Backplane input bit and timing
   output berr_pkg::berr_tx_type local_tx_out, // Local output override
   output berr_pkg::berr_tx_type bp_tx_out // Backplane output override
);
   import berr_pkg::*;

   // =====================================================================
   // Elaboration checks
   // The count register is one 32-bit word and 16 bits is the documented width
   if (COUNT_W < 1 || COUNT_W > 16) begin : g_bad_count
      $error("COUNT_W must lie between 1 and 16");
   end

   localparam int NPORT = 2;
   localparam int NEV = NPORT * `BERR_EV_PER_PORT;
   localparam logic [COUNT_W-1:0] CNT_MAX = '1;
   localparam logic [BERR_LFSR_W-1:0] MASK_SHORT = 23'h00_7FFF;
   localparam logic [BERR_LFSR_W-1:0] MASK_LONG = 23'h7F_FFFF;

   // =====================================================================
   // Functions
   // Next bit of either sequence from a window whose top bit is the oldest
   function automatic logic prbs_next(input logic [BERR_LFSR_W-1:0] st, input logic long_mode);
      logic b;
      b = long_mode ? (st[`BERR_LONG_LEN-1] ^ st[17]) : (st[`BERR_SHORT_LEN-1] ^ st[13]);
      return b;
   endfunction

   // Slot falls inside stream/start/length window
   function automatic logic in_window(input berr_slot_type s, input logic [13:0] start,
                                      input logic [8:0] len);
      logic [BERR_CHAN_W:0] last;
      logic [BERR_CHAN_W-1:0] first;
      first = start[`BERR_STREAM_LSB-1:`BERR_CHAN_LSB];
      last = {1'b0, first} + {1'b0, len};
      return (s.stream == start[13:`BERR_STREAM_LSB]) && (s.channel >= first) &&
             ({1'b0, s.channel} <= last);
   endfunction

   // =====================================================================
   // Register storage
   logic [`BERR_CTRL_W-1:0] ctrl;
   logic [13:0] tx_start [NPORT];
   logic [8:0] tx_len [NPORT];
   logic [13:0] rx_start [NPORT];
   logic [8:0] rx_len [NPORT];
   logic [NEV-1:0] int_status;
   logic [NEV-1:0] int_mask;
   logic [COUNT_W-1:0] err_cnt [NPORT];
   logic [NPORT-1:0] locked;
   wire [NEV-1:0] events;

   // Port-indexed views of the slot and output structs
   berr_slot_type tx_slot [NPORT];
   berr_slot_type rx_slot [NPORT];
   berr_tx_type tx_out [NPORT];
   assign tx_slot[0] = local_tx_slot;
   assign tx_slot[1] = bp_tx_slot;
   assign rx_slot[0] = local_rx_slot;
   assign rx_slot[1] = bp_rx_slot;
   assign local_tx_out = tx_out[0];
   assign bp_tx_out = tx_out[1];

   // =====================================================================
   // APB decode
   // Zero wait states: pready rises in the first access cycle
   wire setup_phase = psel & ~penable;
   wire wr_now = psel & penable & pready & pwrite;
   wire [`BERR_ADDR_W-1:0] a = paddr;
   wire hit_ctrl = (a == `BERR_OFF_CTRL);
   wire hit_lts = (a == `BERR_OFF_L_TX_START);
   wire hit_ltl = (a == `BERR_OFF_L_TX_LEN);
   wire hit_lrs = (a == `BERR_OFF_L_RX_START);
   wire hit_lrl = (a == `BERR_OFF_L_RX_LEN);
   wire hit_lc = (a == `BERR_OFF_L_COUNT);
   wire hit_bts = (a == `BERR_OFF_B_TX_START);
   wire hit_btl = (a == `BERR_OFF_B_TX_LEN);
   wire hit_brs = (a == `BERR_OFF_B_RX_START);
   wire hit_brl = (a == `BERR_OFF_B_RX_LEN);
   wire hit_bc = (a == `BERR_OFF_B_COUNT);
   wire hit_ist = (a == `BERR_OFF_INT_STATUS);
   wire hit_imk = (a == `BERR_OFF_INT_MASK);
   wire hit_lck = (a == `BERR_OFF_LOCK);
   wire mapped = hit_ctrl | hit_lts | hit_ltl | hit_lrs | hit_lrl | hit_lc | hit_bts | hit_btl |
                 hit_brs | hit_brl | hit_bc | hit_ist | hit_imk | hit_lck;

   // Read mux, reserved bits read as zero
   logic [31:0] next_rdata;
   always_comb begin
      next_rdata = 32'h0000_0000;
      case (1'b1)
         hit_ctrl: next_rdata[`BERR_CTRL_W-1:0] = ctrl; // [R9]
         hit_lts: next_rdata[13:0] = tx_start[0]; // [R10]
         hit_ltl: next_rdata[8:0] = tx_len[0];
         hit_lrs: next_rdata[13:0] = rx_start[0]; // [R11]
         hit_lrl: next_rdata[8:0] = rx_len[0];
         hit_lc: next_rdata[COUNT_W-1:0] = err_cnt[0]; // [R12]
         hit_bts: next_rdata[13:0] = tx_start[1];
         hit_btl: next_rdata[8:0] = tx_len[1];
         hit_brs: next_rdata[13:0] = rx_start[1];
         hit_brl: next_rdata[8:0] = rx_len[1];
         hit_bc: next_rdata[COUNT_W-1:0] = err_cnt[1];
         hit_ist: next_rdata[NEV-1:0] = int_status;
         hit_imk: next_rdata[NEV-1:0] = int_mask;
         hit_lck: next_rdata[NPORT-1:0] = locked;
         default: next_rdata = 32'h0000_0000;
      endcase
   end

   // Bus answer flops; data is captured in setup so it is stable through access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= setup_phase;
         pslverr <= setup_phase & ~mapped;
         if (setup_phase && !pwrite) begin
            prdata <= next_rdata;
         end
      end
   end

   // =====================================================================
   // Software-written configuration
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= `BERR_CTRL_RST;
         int_mask <= `BERR_MASK_RST;
         for (int p = 0; p < NPORT; p++) begin
            tx_start[p] <= `BERR_START_RST;
            tx_len[p] <= `BERR_LEN_RST;
            rx_start[p] <= `BERR_START_RST;
            rx_len[p] <= `BERR_LEN_RST;
         end
      end else if (wr_now) begin
         if (hit_ctrl) ctrl <= pwdata[`BERR_CTRL_W-1:0]; // [R9]
         if (hit_imk) int_mask <= pwdata[NEV-1:0];
         if (hit_lts) tx_start[0] <= pwdata[13:0]; // [R10]
         if (hit_ltl) tx_len[0] <= pwdata[8:0];
         if (hit_bts) tx_start[1] <= pwdata[13:0];
         if (hit_btl) tx_len[1] <= pwdata[8:0];
         if (hit_lrs) rx_start[0] <= pwdata[13:0]; // [R11]
         if (hit_lrl) rx_len[0] <= pwdata[8:0];
         if (hit_brs) rx_start[1] <= pwdata[13:0];
         if (hit_brl) rx_len[1] <= pwdata[8:0];
      end
   end

   // =====================================================================
   // Interrupts
   // Write one to clear; a new event in the same cycle wins over the clear
   wire [NEV-1:0] w1c = (wr_now && hit_ist) ? pwdata[NEV-1:0] : '0;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         int_status <= `BERR_STATUS_RST;
         irq <= 1'b0;
      end else begin
         int_status <= (int_status & ~w1c) | events;
         irq <= |(((int_status & ~w1c) | events) & int_mask);
      end
   end

   // =====================================================================
   // Per-port transmitter and receiver
   for (genvar p = 0; p < NPORT; p++) begin : g_port // [R1]
      // Independent enables per direction and port
      wire tx_en = ctrl[`BERR_CTRL_TX_LSB + p]; // [R2]
      wire rx_en = ctrl[`BERR_CTRL_RX_LSB + p]; // [R2]
      wire long_mode = ctrl[`BERR_CTRL_LONG_LSB + p]; // [R3]
      wire [BERR_LFSR_W-1:0] seed = long_mode ? MASK_LONG : MASK_SHORT;

      // Transmit side
      // The window is judged on stream and channel without valid so the override also covers idle bit times
      wire tx_win = in_window(tx_slot[p], tx_start[p], tx_len[p]); // [R4]
      wire tx_hit = tx_en & tx_slot[p].valid & tx_win;
      logic [BERR_LFSR_W-1:0] tx_lfsr;
      wire tx_bit = long_mode ? tx_lfsr[`BERR_LONG_LEN-1] : tx_lfsr[`BERR_SHORT_LEN-1];

      // Generator restarts from the seed whenever disabled, so the seed leads every run
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            tx_lfsr <= MASK_LONG;
         end else if (!tx_en) begin
            tx_lfsr <= MASK_LONG;
         end else if (tx_hit) begin
            tx_lfsr <= {tx_lfsr[BERR_LFSR_W-2:0], prbs_next(tx_lfsr, long_mode)}; // [R17]
         end
      end

      // Output override; the core must not switch this port while blocked
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            tx_out[p] <= '0;
         end else begin
            tx_out[p].insert <= tx_hit; // [R4]
            tx_out[p].data <= tx_bit; // [R3]
            tx_out[p].ignore_cm <= tx_en & tx_win; // [R13]
            tx_out[p].switch_blocked <= tx_en; // [R16]
         end
      end

      // Receive side; channel numbers are raw, with no input delay applied
      wire rx_hit = rx_en & rx_slot[p].valid &
                    in_window(rx_slot[p], rx_start[p], rx_len[p]); // [R5] [R15]
      logic rx_en_q;
      logic [BERR_LFSR_W-1:0] rx_hist;
      logic [BERR_LFSR_W-1:0] rx_ref;
      wire rx_rise = rx_en & ~rx_en_q;
      wire [BERR_LFSR_W-1:0] next_hist = {rx_hist[BERR_LFSR_W-2:0], rx_slot[p].data};
      wire seed_seen = ((next_hist & seed) == seed); // [R6]
      wire expected = prbs_next(rx_ref, long_mode); // [R17]
      wire mismatch = rx_slot[p].data ^ expected;
      wire lock_ev = rx_hit & ~locked[p] & seed_seen;
      wire err_ev = rx_hit & locked[p] & mismatch;
      wire sat_ev = err_ev & (err_cnt[p] == CNT_MAX - 1'b1);

      // Lock search, comparison and saturating count; values freeze while disabled
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            rx_en_q <= 1'b0;
            rx_hist <= '0;
            rx_ref <= '0;
            locked[p] <= 1'b0;
            err_cnt[p] <= '0;
         end else begin
            rx_en_q <= rx_en;
            if (rx_rise) begin
               rx_hist <= '0; // [R18]
               locked[p] <= 1'b0;
               err_cnt[p] <= '0;
            end else if (rx_hit) begin
               rx_hist <= next_hist;
               if (!locked[p]) begin
                  if (seed_seen) begin
                     locked[p] <= 1'b1; // [R6]
                     rx_ref <= seed;
                  end
               end else begin
                  rx_ref <= {rx_ref[BERR_LFSR_W-2:0], expected};
                  if (mismatch && err_cnt[p] != CNT_MAX) begin
                     err_cnt[p] <= err_cnt[p] + 1'b1; // [R7] [R8]
                  end
               end
            end
         end
      end

      assign events[p*`BERR_EV_PER_PORT + `BERR_EV_LOCK] = lock_ev;
      assign events[p*`BERR_EV_PER_PORT + `BERR_EV_ERR] = err_ev;
      assign events[p*`BERR_EV_PER_PORT + `BERR_EV_SAT] = sat_ev;
   end

endmodule

`default_nettype wire
